// ==== adcsq_defines.svh ====
// Register indices, field positions, reset values and timing counts
`ifndef ADCSQ_DEFINES_SVH
`define ADCSQ_DEFINES_SVH

`define ADCSQ_IDX_TK         8'hBA
`define ADCSQ_IDX_CN         8'hE8
`define ADCSQ_IDX_RES_LO     8'hBD
`define ADCSQ_IDX_RES_HI     8'hBE
`define ADCSQ_IDX_UPPER_LO   8'hC3
`define ADCSQ_IDX_UPPER_HI   8'hC4
`define ADCSQ_IDX_LOWER_LO   8'hC5
`define ADCSQ_IDX_LOWER_HI   8'hC6
`define ADCSQ_IDX_IRQ_STAT   8'hF0
`define ADCSQ_IDX_IRQ_MASK   8'hF1

`define ADCSQ_CN_EN          7
`define ADCSQ_CN_BURST       6
`define ADCSQ_CN_DONE        5
`define ADCSQ_CN_BUSY        4
`define ADCSQ_CN_WIN         3
`define ADCSQ_CN_LJST        2
`define ADCSQ_CN_CM_LSB      0
`define ADCSQ_TK_PWR_LSB     4
`define ADCSQ_TK_TM_LSB      2
`define ADCSQ_TK_TK_LSB      0
`define ADCSQ_IRQ_DONE       0
`define ADCSQ_IRQ_WIN        1

`define ADCSQ_RST_TK         8'hFF
`define ADCSQ_RST_CN         8'h00
`define ADCSQ_RST_LIMIT      8'hFF
`define ADCSQ_RST_MASK       2'h0

`define ADCSQ_CM_SOFT        2'h0
`define ADCSQ_CM_TIMER1      2'h1
`define ADCSQ_CM_PIN         2'h2
`define ADCSQ_CM_TIMER2      2'h3

`define ADCSQ_CLK_NS         100
`define ADCSQ_PWR_STEP_NS    200
`define ADCSQ_PWR_STEP_CYC   ((`ADCSQ_PWR_STEP_NS + `ADCSQ_CLK_NS - 1) / `ADCSQ_CLK_NS)
`define ADCSQ_SAR_DIV        2
`define ADCSQ_POST_EXTRA     2

`endif

// ==== adcsq_pkg.sv ====
// Types shared by the converter sequencer modules
package adcsq_pkg;

    typedef enum logic [1:0] {
        ADCSQ_IDLE,
        ADCSQ_POWERUP,
        ADCSQ_TRACK,
        ADCSQ_CONVERT
    } adcsq_state_type;

    typedef struct packed {
        logic       power_on;
        logic       very_low_power;
        logic [1:0] track_mode;
        logic       tracking;
        logic       go;
    } adcsq_core_ctrl_type;

    typedef struct packed {
        logic        done;
        logic [11:0] result;
    } adcsq_core_stat_type;

    typedef struct packed {
        logic [15:0] value;
        logic [15:0] upper;
        logic [15:0] lower;
    } adcsq_cmp_type;

endpackage

// ==== adcsq_edge.sv ====
// Two-stage synchroniser and rising-edge detector for the start pin
`timescale 1ns/1ns
module adcsq_edge
    import adcsq_pkg::*;
(
    input  wire logic pclk,     // System clock
    input  wire logic presetn,  // Async reset, active low
    input  wire logic pin_in,   // Asynchronous pin level
    output logic      rise      // One-cycle pulse on a rising edge
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic rise;
    } adcsq_edge_state_type;

    adcsq_edge_state_type st_ff;
    adcsq_edge_state_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = pin_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.rise = st_ff.s2 & ~st_ff.s3;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rise = st_ff.rise;
endmodule // adcsq_edge

// ==== adcsq_window.sv ====
// Window comparator: flags a result that meets the limit condition
`timescale 1ns/1ns
module adcsq_window
    import adcsq_pkg::*;
(
    input  wire logic          pclk,     // System clock
    input  wire logic          presetn,  // Async reset, active low
    input  wire adcsq_cmp_type cmp,      // Value and limits, same format
    input  wire logic          eval,     // New result present
    output logic               match     // One-cycle pulse on a hit
);
    typedef struct packed {
        logic match;
    } adcsq_win_state_type;

    adcsq_win_state_type st_ff;
    adcsq_win_state_type nxt_st;
    logic                above;
    logic                below;

    always_comb begin
        above = cmp.value > cmp.upper;
        below = cmp.value < cmp.lower;
        nxt_st.match = 1'b0;
        if (eval) begin
            // Limit order alone picks inside or outside
            if (cmp.lower > cmp.upper) begin
                nxt_st.match = above & below;
            end else begin
                nxt_st.match = above | below;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign match = st_ff.match;
endmodule // adcsq_window

// ==== adcsq_top.sv ====
// Converter sequencer: start select, power, tracking, window, APB regs
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`include "adcsq_defines.svh"
module adcsq_top
    import adcsq_pkg::*;
(
    input  wire logic                 pclk,                  // System clock
    input  wire logic                 presetn,               // Reset, low
    input  wire logic                 psel,                  // APB select
    input  wire logic                 penable,               // APB enable
    input  wire logic                 pwrite,                // APB write
    input  wire logic [11:0]          paddr,                 // APB address
    input  wire logic [31:0]          pwdata,                // APB wdata
    output logic      [31:0]          prdata,                // APB rdata
    output logic                      pready,                // APB ready
    output logic                      pslverr,               // APB error
    input  wire logic                 timer1_ovf,            // Timer 1 pulse
    input  wire logic                 timer2_ovf,            // Timer 2 pulse
    input  wire logic                 ext_convert_start_pin, // Start pin
    output adcsq_core_ctrl_type       core_ctrl,             // To core
    input  wire adcsq_core_stat_type  core_stat,             // From core
    output logic                      irq                    // Interrupt
);
    typedef struct packed {
        adcsq_state_type state;
        logic [7:0]      tk;
        logic            enable;
        logic            burst;
        logic            done;
        logic            win;
        logic            ljst;
        logic [1:0]      cm;
        logic [7:0]      upper_hi;
        logic [7:0]      upper_lo;
        logic [7:0]      lower_hi;
        logic [7:0]      lower_lo;
        logic [11:0]     result;
        logic [1:0]      mask;
        logic [5:0]      count;
        logic            go;
        logic            eval;
        logic [31:0]     rdata;
    } adcsq_top_state_type;

    adcsq_top_state_type st_ff;
    adcsq_top_state_type nxt_st;

    logic          pin_rise;
    logic          win_hit;
    logic          access;
    logic          wr;
    logic [7:0]    idx;
    logic          mapped;
    logic          start_req;
    logic          soft_start;
    logic          accept;
    logic [15:0]   fmt_val;
    adcsq_cmp_type cmp;

    // Output word layout shared by result registers and the comparator
    function automatic logic [15:0] fmt(input logic [11:0] r,
                                        input logic        lj);
        if (lj) begin
            fmt = {r, 4'h0};
        end else begin
            fmt = {4'h0, r};
        end
    endfunction

    function automatic logic [5:0] post_cycles(input logic [1:0] sel);
        logic [5:0] sar;
        sar = 6'(2) << sel;
        post_cycles = 6'(sar * `ADCSQ_SAR_DIV + `ADCSQ_POST_EXTRA);
    endfunction

    function automatic logic [5:0] pwr_cycles(input logic [3:0] n);
        pwr_cycles = 6'((n + 5'h01) * `ADCSQ_PWR_STEP_CYC);
    endfunction

    adcsq_edge u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  (ext_convert_start_pin),
        .rise    (pin_rise)
    );

    adcsq_window u_window (
        .pclk    (pclk),
        .presetn (presetn),
        .cmp     (cmp),
        .eval    (st_ff.eval),
        .match   (win_hit)
    );

    always_comb begin
        fmt_val = fmt(st_ff.result, st_ff.ljst);
        cmp.value = fmt_val;
        cmp.upper = {st_ff.upper_hi, st_ff.upper_lo};
        cmp.lower = {st_ff.lower_hi, st_ff.lower_lo};
    end

    always_comb begin
        access = psel & penable;
        wr = access & pwrite;
        idx = paddr[9:2];
        unique case (idx)
            `ADCSQ_IDX_TK, `ADCSQ_IDX_CN,
            `ADCSQ_IDX_RES_LO, `ADCSQ_IDX_RES_HI,
            `ADCSQ_IDX_UPPER_LO, `ADCSQ_IDX_UPPER_HI,
            `ADCSQ_IDX_LOWER_LO, `ADCSQ_IDX_LOWER_HI,
            `ADCSQ_IDX_IRQ_STAT, `ADCSQ_IDX_IRQ_MASK: begin
                mapped = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
        soft_start = wr & mapped & (idx == `ADCSQ_IDX_CN)
                     & pwdata[`ADCSQ_CN_BUSY];
        unique case (st_ff.cm)
            `ADCSQ_CM_SOFT:   start_req = soft_start;
            `ADCSQ_CM_TIMER1: start_req = timer1_ovf;
            `ADCSQ_CM_PIN:    start_req = pin_rise;
            `ADCSQ_CM_TIMER2: start_req = timer2_ovf;
        endcase
        // Starts while busy are dropped rather than queued
        accept = start_req & (st_ff.state == ADCSQ_IDLE)
                 & (st_ff.enable | st_ff.burst);
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.go = 1'b0;
        nxt_st.eval = 1'b0;

        unique case (st_ff.state)
            ADCSQ_IDLE: begin
                if (accept) begin
                    if (st_ff.burst & ~st_ff.enable) begin
                        nxt_st.state = ADCSQ_POWERUP;
                        nxt_st.count = pwr_cycles(
                            st_ff.tk[`ADCSQ_TK_PWR_LSB +: 4]);
                    end else if (st_ff.tk[`ADCSQ_TK_TM_LSB]) begin
                        nxt_st.state = ADCSQ_TRACK;
                        nxt_st.count = post_cycles(
                            st_ff.tk[`ADCSQ_TK_TK_LSB +: 2]);
                    end else begin
                        nxt_st.state = ADCSQ_CONVERT;
                        nxt_st.go = 1'b1;
                    end
                end
            end
            ADCSQ_POWERUP: begin
                if (st_ff.count == 6'h01) begin
                    if (st_ff.tk[`ADCSQ_TK_TM_LSB]) begin
                        nxt_st.state = ADCSQ_TRACK;
                        nxt_st.count = post_cycles(
                            st_ff.tk[`ADCSQ_TK_TK_LSB +: 2]);
                    end else begin
                        nxt_st.state = ADCSQ_CONVERT;
                        nxt_st.go = 1'b1;
                    end
                end else begin
                    nxt_st.count = st_ff.count - 6'h01;
                end
            end
            ADCSQ_TRACK: begin
                if (st_ff.count == 6'h01) begin
                    nxt_st.state = ADCSQ_CONVERT;
                    nxt_st.go = 1'b1;
                end else begin
                    nxt_st.count = st_ff.count - 6'h01;
                end
            end
            ADCSQ_CONVERT: begin
                if (core_stat.done) begin
                    nxt_st.state = ADCSQ_IDLE;
                    nxt_st.result = core_stat.result;
                    nxt_st.eval = 1'b1;
                end
            end
        endcase

        // Register reads are captured in the setup cycle
        if (psel & ~penable & ~pwrite) begin
            nxt_st.rdata = 32'h0000_0000;
            unique case (idx)
                `ADCSQ_IDX_TK:       nxt_st.rdata[7:0] = st_ff.tk;
                `ADCSQ_IDX_CN:       nxt_st.rdata[7:0] = {
                    st_ff.enable, st_ff.burst, st_ff.done,
                    (st_ff.state != ADCSQ_IDLE),
                    st_ff.win, st_ff.ljst, st_ff.cm};
                `ADCSQ_IDX_RES_LO:   nxt_st.rdata[7:0] = fmt_val[7:0];
                `ADCSQ_IDX_RES_HI:   nxt_st.rdata[7:0] = fmt_val[15:8];
                `ADCSQ_IDX_UPPER_LO: nxt_st.rdata[7:0] = st_ff.upper_lo;
                `ADCSQ_IDX_UPPER_HI: nxt_st.rdata[7:0] = st_ff.upper_hi;
                `ADCSQ_IDX_LOWER_LO: nxt_st.rdata[7:0] = st_ff.lower_lo;
                `ADCSQ_IDX_LOWER_HI: nxt_st.rdata[7:0] = st_ff.lower_hi;
                `ADCSQ_IDX_IRQ_STAT: nxt_st.rdata[1:0] =
                    {st_ff.win, st_ff.done};
                `ADCSQ_IDX_IRQ_MASK: nxt_st.rdata[1:0] = st_ff.mask;
                default:             nxt_st.rdata = 32'h0000_0000;
            endcase
            if (!mapped) begin
                nxt_st.rdata = 32'h0000_0000;
            end
        end

        if (wr & mapped) begin
            unique case (idx)
                `ADCSQ_IDX_TK: begin
                    nxt_st.tk = pwdata[7:0];
                end
                `ADCSQ_IDX_CN: begin
                    nxt_st.enable = pwdata[`ADCSQ_CN_EN];
                    nxt_st.burst = pwdata[`ADCSQ_CN_BURST];
                    nxt_st.ljst = pwdata[`ADCSQ_CN_LJST];
                    nxt_st.cm = pwdata[`ADCSQ_CN_CM_LSB +: 2];
                    // Flags may be cleared, never set, by software
                    nxt_st.done = st_ff.done
                                  & pwdata[`ADCSQ_CN_DONE];
                    nxt_st.win = st_ff.win & pwdata[`ADCSQ_CN_WIN];
                end
                `ADCSQ_IDX_UPPER_LO: nxt_st.upper_lo = pwdata[7:0];
                `ADCSQ_IDX_UPPER_HI: nxt_st.upper_hi = pwdata[7:0];
                `ADCSQ_IDX_LOWER_LO: nxt_st.lower_lo = pwdata[7:0];
                `ADCSQ_IDX_LOWER_HI: nxt_st.lower_hi = pwdata[7:0];
                `ADCSQ_IDX_IRQ_STAT: begin
                    if (pwdata[`ADCSQ_IRQ_DONE]) begin
                        nxt_st.done = 1'b0;
                    end
                    if (pwdata[`ADCSQ_IRQ_WIN]) begin
                        nxt_st.win = 1'b0;
                    end
                end
                `ADCSQ_IDX_IRQ_MASK: nxt_st.mask = pwdata[1:0];
                default: begin
                end
            endcase
        end

        // Hardware set is applied last so it beats a same-cycle clear
        if ((st_ff.state == ADCSQ_CONVERT) & core_stat.done) begin
            nxt_st.done = 1'b1;
        end
        if (win_hit) begin
            nxt_st.win = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.state <= ADCSQ_IDLE;
            st_ff.tk <= `ADCSQ_RST_TK;
            st_ff.upper_hi <= `ADCSQ_RST_LIMIT;
            st_ff.upper_lo <= `ADCSQ_RST_LIMIT;
            st_ff.lower_hi <= `ADCSQ_RST_LIMIT;
            st_ff.lower_lo <= `ADCSQ_RST_LIMIT;
            st_ff.mask <= `ADCSQ_RST_MASK;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_comb begin
        // Without burst the enable bit alone rules power
        core_ctrl.power_on = st_ff.enable
                             | (st_ff.burst
                                & (st_ff.state != ADCSQ_IDLE));
        core_ctrl.very_low_power = st_ff.burst & ~st_ff.enable
                                   & (st_ff.state == ADCSQ_IDLE);
        core_ctrl.track_mode = st_ff.tk[`ADCSQ_TK_TM_LSB +: 2];
        core_ctrl.tracking = (st_ff.state == ADCSQ_TRACK);
        core_ctrl.go = st_ff.go;
        irq = |({st_ff.win, st_ff.done} & st_ff.mask);
        prdata = st_ff.rdata;
        pready = 1'b1;
        pslverr = access & ~mapped;
    end
endmodule // adcsq_top

// ==== adcsq_assertions.sv ====
// Port checker for the converter sequencer, bound to its top module
`timescale 1ns/1ns
`include "adcsq_defines.svh"
module adcsq_checker
    import adcsq_pkg::*;
(
    input wire logic                pclk,      // System clock
    input wire logic                presetn,   // Reset, low
    input wire logic                psel,      // APB select
    input wire logic                penable,   // APB enable
    input wire logic                pwrite,    // APB write
    input wire logic [11:0]         paddr,     // APB address
    input wire logic [31:0]         pwdata,    // APB wdata
    input wire logic [31:0]         prdata,    // APB rdata
    input wire logic                pready,    // APB ready
    input wire logic                pslverr,   // APB error
    input wire logic                timer1_ovf, // Timer 1 pulse
    input wire logic                timer2_ovf, // Timer 2 pulse
    input wire logic                ext_convert_start_pin, // Start pin
    input wire adcsq_core_ctrl_type core_ctrl, // To core
    input wire adcsq_core_stat_type core_stat, // From core
    input wire logic                irq        // Interrupt
);
    logic       wr;
    logic [7:0] cn_ff;
    logic [7:0] tk_ff;
    logic [1:0] mask_ff;
    logic [5:0] trk_ff;
    logic [5:0] pon_ff;
    assign wr = psel && penable && pwrite;
    // Shadow copies of the config bytes, so relations need no internals
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cn_ff <= `ADCSQ_RST_CN;
            tk_ff <= `ADCSQ_RST_TK;
            mask_ff <= `ADCSQ_RST_MASK;
            trk_ff <= 6'h00;
            pon_ff <= 6'h00;
        end else begin
            if (wr && paddr == {2'b00, `ADCSQ_IDX_CN, 2'b00})
                cn_ff <= pwdata[7:0];
            if (wr && paddr == {2'b00, `ADCSQ_IDX_TK, 2'b00})
                tk_ff <= pwdata[7:0];
            if (wr && paddr == {2'b00, `ADCSQ_IDX_IRQ_MASK, 2'b00})
                mask_ff <= pwdata[1:0];
            // Saturate so idle tracking or power cannot wrap the count
            trk_ff <= !core_ctrl.tracking ? 6'h00
                      : trk_ff + 6'(trk_ff != 6'h3F);
            pon_ff <= !core_ctrl.power_on ? 6'h00
                      : pon_ff + 6'(pon_ff != 6'h3F);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    power_follow_a: assert property (
        !cn_ff[6] |-> core_ctrl.power_on == cn_ff[7])
        else $error("power does not follow enable");
    burst_keep_a: assert property (
        cn_ff[7:6] == 2'b11 |-> core_ctrl.power_on && !core_ctrl.very_low_power)
        else $error("burst with enable dropped power");
    powerup_wait_a: assert property (
        core_ctrl.go && cn_ff[7:6] == 2'b01
        |-> pon_ff >= {1'b0, tk_ff[7:4], 1'b0} + 6'h02)
        else $error("conversion before power-up time");
    track_mode_a: assert property (
        core_ctrl.track_mode == tk_ff[3:2])
        else $error("tracking mode not from config");
    post_track_a: assert property (
        $fell(core_ctrl.tracking) && $stable(tk_ff) && tk_ff[3:2] == 2'b01
        |-> trk_ff == (6'h04 << tk_ff[1:0]) + 6'h02)
        else $error("post-track length wrong");
    go_pulse_a: assert property (
        core_ctrl.go |=> !core_ctrl.go)
        else $error("convert pulse too long");
    shutdown_a: assert property (
        cn_ff[7:6] == 2'b00 |-> !core_ctrl.go)
        else $error("conversion while shut down");
    done_irq_a: assert property (
        core_stat.done && mask_ff[0] |=> irq)
        else $error("done did not raise interrupt");
    irq_masked_a: assert property (
        mask_ff == 2'h0 |-> !irq)
        else $error("interrupt while fully masked");
endmodule // adcsq_checker

bind adcsq_top adcsq_checker chk_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timer1_ovf,
    .timer2_ovf, .ext_convert_start_pin, .core_ctrl, .core_stat, .irq);

// ==== adcsq_core_model.sv ====
// Behavioural converter core: answers each convert pulse given with power on after a delay
`timescale 1ns/1ns
module adcsq_core_model
    import adcsq_pkg::*;
(
    input  wire logic                pclk,      // System clock
    input  wire logic                presetn,   // Reset, low
    input  wire adcsq_core_ctrl_type core_ctrl, // From sequencer
    input  wire logic [11:0]         res_val,   // Next result
    input  wire logic [7:0]          lat,       // Cycles from go to done
    output adcsq_core_stat_type      core_stat  // To sequencer
);
    logic [7:0] cnt_ff;
    logic       run_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ff <= 1'b0;
            cnt_ff <= 8'h00;
            core_stat <= '0;
        end else begin
            core_stat.done <= 1'b0;
            // Result is only valid with done; keep it moving otherwise
            core_stat.result <= ~core_stat.result;
            if (core_ctrl.go && core_ctrl.power_on) begin
                run_ff <= 1'b1;
                cnt_ff <= lat;
            end else if (run_ff && cnt_ff <= 8'h01) begin
                run_ff <= 1'b0;
                core_stat.done <= 1'b1;
                core_stat.result <= res_val;
            end else begin
                cnt_ff <= cnt_ff - 8'h01;
            end
        end
    end
endmodule // adcsq_core_model

// ==== adc_sequencer_window_detect_bench.sv ====
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
`include "adcsq_defines.svh"
module adc_sequencer_window_detect_bench;
    import adcsq_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, irq, er;
    logic timer1_ovf = 1'b0, timer2_ovf = 1'b0, ext_convert_start_pin = 1'b0;
    logic [11:0] paddr = 12'h000, res_val = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [7:0] lat = 8'h04, rd, cn;
    adcsq_core_ctrl_type core_ctrl;
    adcsq_core_stat_type core_stat;
    int errors = 0, tests_run = 0, cyc = 0;

    adcsq_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .timer1_ovf, .timer2_ovf,
        .ext_convert_start_pin, .core_ctrl, .core_stat, .irq);
    adcsq_core_model core_u (.pclk, .presetn, .core_ctrl, .res_val, .lat,
        .core_stat);

    always #50 pclk = ~pclk;
    // Hang guard; the full run needs well under 3000 cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_sim;
        end
    end

    task automatic chk(input string nm, input logic [11:0] e,
                       input logic [11:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [7:0] e,
                        input string nm);
        apb(1'b0, idx, 8'h00);
        chk(nm, {4'h0, e}, {4'h0, rd});
    endtask
    task automatic setcn(input logic [7:0] v);
        cn = v;
        apb(1'b1, `ADCSQ_IDX_CN, v);
    endtask
    task automatic conv(input logic [1:0] cm, input logic peek);
        int n;
        if (cm == `ADCSQ_CM_SOFT) apb(1'b1, `ADCSQ_IDX_CN, cn | 8'h10);
        else begin
            timer1_ovf <= (cm == `ADCSQ_CM_TIMER1);
            timer2_ovf <= (cm == `ADCSQ_CM_TIMER2);
            ext_convert_start_pin <= (cm == `ADCSQ_CM_PIN);
            @(posedge pclk);
            timer1_ovf <= 1'b0;
            timer2_ovf <= 1'b0;
            repeat (3) @(posedge pclk);
            ext_convert_start_pin <= 1'b0;
        end
        if (peek) rchk(`ADCSQ_IDX_CN, cn | 8'h10, "busy");
        n = 0;
        while (core_stat.done !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chk("done pulse", 12'h001, {11'h0, core_stat.done});
        repeat (4) @(posedge pclk);
    endtask
    task automatic wcase(input logic [15:0] gt, input logic [15:0] lt,
                         input logic [11:0] r, input logic hit);
        apb(1'b1, `ADCSQ_IDX_UPPER_HI, gt[15:8]);
        apb(1'b1, `ADCSQ_IDX_UPPER_LO, gt[7:0]);
        apb(1'b1, `ADCSQ_IDX_LOWER_HI, lt[15:8]);
        apb(1'b1, `ADCSQ_IDX_LOWER_LO, lt[7:0]);
        res_val <= r;
        setcn(8'h80);
        conv(`ADCSQ_CM_SOFT, 1'b0);
        rchk(`ADCSQ_IDX_CN, {4'hA, hit, 3'h0}, "window flag");
    endtask

    task automatic t_reset;
        rchk(`ADCSQ_IDX_TK, `ADCSQ_RST_TK, "tk reset");
        rchk(`ADCSQ_IDX_CN, `ADCSQ_RST_CN, "cn reset");
        rchk(`ADCSQ_IDX_UPPER_HI, `ADCSQ_RST_LIMIT, "upper reset");
        rchk(`ADCSQ_IDX_LOWER_LO, `ADCSQ_RST_LIMIT, "lower reset");
        apb(1'b0, 8'h10, 8'h00);
        chk("unmapped", 12'h001, {11'h0, er});
        apb(1'b1, `ADCSQ_IDX_TK, 8'h08);
        apb(1'b1, `ADCSQ_IDX_CN, 8'h10);
        repeat (20) @(posedge pclk);
        rchk(`ADCSQ_IDX_CN, 8'h00, "no start when off");
    endtask
    task automatic t_soft;
        lat <= 8'd20;
        res_val <= 12'hABC;
        setcn(8'h80);
        conv(`ADCSQ_CM_SOFT, 1'b1);
        lat <= 8'h04;
        rchk(`ADCSQ_IDX_CN, 8'hA8, "done set");
        rchk(`ADCSQ_IDX_RES_HI, 8'h0A, "right high");
        rchk(`ADCSQ_IDX_RES_LO, 8'hBC, "right low");
        res_val <= 12'h5E7;
        setcn(8'h84);
        conv(`ADCSQ_CM_SOFT, 1'b0);
        rchk(`ADCSQ_IDX_RES_HI, 8'h5E, "left high");
        rchk(`ADCSQ_IDX_RES_LO, 8'h70, "left low");
    endtask
    task automatic t_sources;
        for (int m = 1; m < 4; m++) begin
            setcn(8'h80 | 8'(m));
            conv(2'(m), 1'b0);
        end
    endtask
    task automatic t_track;
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, `ADCSQ_IDX_TK, 8'h04 | 8'(k));
            setcn(8'h80);
            conv(`ADCSQ_CM_SOFT, 1'b0);
        end
        apb(1'b1, `ADCSQ_IDX_TK, 8'h0D);
        conv(`ADCSQ_CM_SOFT, 1'b0);
    endtask
    task automatic t_burst;
        apb(1'b1, `ADCSQ_IDX_TK, 8'h38);
        setcn(8'h40);
        chk("very low power", 12'h001, {11'h0, core_ctrl.very_low_power});
        conv(`ADCSQ_CM_SOFT, 1'b0);
        setcn(8'hC0);
        chk("burst powered", 12'h001, {11'h0, core_ctrl.power_on});
        conv(`ADCSQ_CM_SOFT, 1'b0);
        setcn(8'h00);
        chk("power off", 12'h000, {11'h0, core_ctrl.power_on});
    endtask
    task automatic t_window;
        apb(1'b1, `ADCSQ_IDX_TK, 8'h08);
        wcase(16'h0100, 16'h0050, 12'hABC, 1'b1);
        wcase(16'h0100, 16'h0050, 12'h080, 1'b0);
        wcase(16'h0100, 16'h0F00, 12'hABC, 1'b1);
        wcase(16'h0100, 16'h0F00, 12'hF80, 1'b0);
        rchk(`ADCSQ_IDX_LOWER_HI, 8'h0F, "lower high");
        rchk(`ADCSQ_IDX_UPPER_HI, 8'h01, "upper high");
    endtask
    task automatic t_irq;
        apb(1'b1, `ADCSQ_IDX_IRQ_MASK, 8'h03);
        res_val <= 12'h200;
        setcn(8'h80);
        conv(`ADCSQ_CM_SOFT, 1'b0);
        chk("irq on", 12'h001, {11'h0, irq});
        rchk(`ADCSQ_IDX_IRQ_STAT, 8'h03, "status both");
        apb(1'b1, `ADCSQ_IDX_IRQ_STAT, 8'h01);
        rchk(`ADCSQ_IDX_IRQ_STAT, 8'h02, "status w1c");
        apb(1'b1, `ADCSQ_IDX_IRQ_MASK, 8'h01);
        chk("irq masked", 12'h000, {11'h0, irq});
        apb(1'b1, `ADCSQ_IDX_IRQ_STAT, 8'h02);
        rchk(`ADCSQ_IDX_IRQ_STAT, 8'h00, "status clear");
    endtask

    task automatic end_sim;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_soft;
        t_sources;
        t_track;
        t_burst;
        t_window;
        t_irq;
        end_sim;
    end
endmodule // adc_sequencer_window_detect_bench
